// [design/bocr_pin_sync.sv]
`timescale 1ns/1ps
// two-stage synchroniser with edge detection on the settled stage
module bocr_pin_sync #(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  // pins in, settled levels and edges out
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  // meta_r feeds only sync_r
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '1;
      sync_r <= '1;
      prev_r <= '1;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // edges from settled and delayed stages
  assign sync_o = sync_r;
  assign rise_o = sync_r & ~prev_r;
  assign fall_o = ~sync_r & prev_r;

endmodule

// [design/bocr_pkg.sv]
// Behaviour
// - bits 5..0 of register 0x10 hold the read/write output level code.
// - bit 6 of register 0x10 selects the low (0) or high (1) output range.
// - bit 0 of register 0x11 selects auto light-load (0) or forced pwm (1).
// - bit 1 of register 0x13 reads 1 while the output is in regulation.
// - read-only bits ignore writes; all but the bit 1 status flag of 0x13 read back as zero here.
// - high range target is 1.250 V plus 50 mV per code step, up to 4.400 V.
// - low range codes 0x00..0x11 are unavailable; 0x12 is 1.100 V.
// - registers are reached only by two-wire single byte write and read; here further bytes in one frame write or read the same register again.
package bocr_pkg;

  // two-wire slave address, default 1010011
  localparam logic [6:0] SLAVE_ADDR_DEF = 7'h53;
  localparam logic [3:0] BYTE_BITS      = 4'h8;

  // register offsets
  localparam logic [7:0] OFS_LEVEL  = 8'h10;
  localparam logic [7:0] OFS_MODE   = 8'h11;
  localparam logic [7:0] OFS_TRIM_A = 8'h12;
  localparam logic [7:0] OFS_STAT   = 8'h13;

  // field positions
  localparam int CODE_MSB     = 5;
  localparam int RANGE_BIT    = 6;
  localparam int FPWM_BIT     = 0;
  localparam int TRIM_A_LSB   = 6;
  localparam int TRIM_B0_BIT  = 0;
  localparam int PGOOD_BIT    = 1;
  localparam int TRIM_B2_BIT  = 2;
  localparam int TRIM_B4_BIT  = 4;

  // reset values
  localparam logic [5:0] RST_CODE   = 6'h12;
  localparam logic       RST_RANGE  = 1'h0;
  localparam logic       RST_FPWM   = 1'h0;
  localparam logic [1:0] RST_TRIM_A = 2'h0;
  localparam logic [2:0] RST_TRIM_B = 3'h0;

  // output level arithmetic, millivolts
  localparam logic [12:0] HI_BASE_MV     = 13'h04E2;
  localparam logic [12:0] HI_STEP_MV     = 13'h0032;
  localparam logic [5:0]  LOW_FIRST_CODE = 6'h12;
  localparam logic [11:0] LOW_MV [0:45] = '{
    12'h44C, 12'h465, 12'h47E, 12'h497, 12'h4B0, 12'h4C9, 12'h4E7, 12'h500,
    12'h519, 12'h532, 12'h54B, 12'h564, 12'h57D, 12'h596, 12'h5AF, 12'h5C8,
    12'h5E1, 12'h5FA, 12'h613, 12'h631, 12'h64A, 12'h663, 12'h67C, 12'h695,
    12'h6AE, 12'h6C7, 12'h6E0, 12'h6F9, 12'h712, 12'h72B, 12'h744, 12'h762,
    12'h77B, 12'h794, 12'h7AD, 12'h7C6, 12'h7DF, 12'h7F8, 12'h811, 12'h82A,
    12'h843, 12'h85C, 12'h875, 12'h88E, 12'h898, 12'h8C5};

  // timing: data out hold after clock low
  localparam int CLK_MHZ     = 250;
  localparam int T_HD_OUT_NS = 300;
  localparam int HD_CYC      = (T_HD_OUT_NS * CLK_MHZ + 999) / 1000;
  localparam logic [6:0] HD_CYC_W = 7'(HD_CYC);

  // serial engine states
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h2,
    ST_PTR       = 4'h3,
    ST_PTR_ACK   = 4'h4,
    ST_WDATA     = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA     = 4'h7,
    ST_RDATA_ACK = 4'h8
  } bocr_state_t;

  // register write strobe
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } bocr_wr_t;

  // level lookup result
  typedef struct packed {
    logic        valid;
    logic [12:0] mv;
  } bocr_level_t;

endpackage

// [design/bocr_regs.sv]
`timescale 1ns/1ps
// control registers of the first buck converter behind a two-wire slave
module bocr_regs
  import bocr_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEF
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // two-wire pins, data is open drain
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  // converter status in
  input  wire logic        power_good_i,
  // converter controls out
  output logic [5:0]       output_level_code_o,
  output logic             level_range_select_o,
  output logic             forced_pwm_o,
  output logic [1:0]       trim_a_o,
  output logic [2:0]       trim_b_o,
  output logic             level_valid_o,
  output logic [12:0]      target_mv_o
);

  if (SLAVE_ADDR == 7'h00) begin : g_chk_addr
    $error("slave address zero is the general call");
  end
  if (HD_CYC < 1 || HD_CYC > 127) begin : g_chk_hold
    $error("hold count does not fit its counter");
  end

  // pin synchronisers
  logic [2:0] pin_s;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  bocr_pin_sync #(
    .W (3)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({power_good_i, sda_i, scl_i}),
    .sync_o    (pin_s),
    .rise_o    (pin_rise),
    .fall_o    (pin_fall)
  );

  // bus conditions
  wire scl_s    = pin_s[0];
  wire sda_s    = pin_s[1];
  wire pgood_s  = pin_s[2];
  wire scl_rise = pin_rise[0];
  wire scl_fall = pin_fall[0];
  wire start_w  = scl_s & pin_fall[1];
  wire stop_w   = scl_s & pin_rise[1];

  // register state
  logic [5:0]  code_r;
  logic        range_r;
  logic        fpwm_r;
  logic [1:0]  trim_a_r;
  logic [2:0]  trim_b_r;
  logic        lvl_valid_r;
  logic [12:0] mv_r;

  // serial engine state
  bocr_state_t state_r, state_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic [7:0]  shift_r, shift_nxt;
  logic [7:0]  tx_r, tx_nxt;
  logic [7:0]  ptr_r, ptr_nxt;
  logic        rw_r, rw_nxt;
  logic        acked_r, acked_nxt;
  logic        oe_want_r, oe_nxt;
  bocr_wr_t    wr_r, wr_nxt;
  logic [6:0]  hold_r;
  logic        sda_oe_r;

  // read value of one offset; unmapped reads zero
  function automatic logic [7:0] read_mux(input logic [7:0] ofs,
    input logic [5:0] c, input logic [1:0] ta, input logic [2:0] tb,
    input logic r, f, pg);
    logic [7:0] v = 8'h00;
    if (ofs == OFS_LEVEL) begin
      v[CODE_MSB:0] = c;
      v[RANGE_BIT]  = r;
    end else if (ofs == OFS_MODE) begin
      v[FPWM_BIT] = f;
    end else if (ofs == OFS_TRIM_A) begin
      v[7:TRIM_A_LSB] = ta;
    end else if (ofs == OFS_STAT) begin
      v[TRIM_B0_BIT] = tb[0];
      v[PGOOD_BIT]   = pg;
      v[TRIM_B2_BIT] = tb[1];
      v[TRIM_B4_BIT] = tb[2];
    end
    return v;
  endfunction

  // target level from code and range
  function automatic bocr_level_t level_of(input logic [5:0] c,
                                           input logic r);
    bocr_level_t l   = '0;
    logic [5:0]  idx = c - LOW_FIRST_CODE;
    if (r) begin
      l.valid = 1'b1;
      l.mv    = HI_BASE_MV + 13'(HI_STEP_MV * c);
    end else if (c >= LOW_FIRST_CODE) begin
      l.valid = 1'b1;
      l.mv    = {1'b0, LOW_MV[idx]};
    end
    return l;
  endfunction

  wire [7:0]        rd_byte = read_mux(ptr_r, code_r, trim_a_r, trim_b_r,
                                       range_r, fpwm_r, pgood_s);
  wire bocr_level_t lvl_w   = level_of(code_r, range_r);

  // write decode
  wire hit_level = wr_r.wr && (wr_r.addr == OFS_LEVEL);
  wire hit_mode  = wr_r.wr && (wr_r.addr == OFS_MODE);
  wire hit_trima = wr_r.wr && (wr_r.addr == OFS_TRIM_A);
  wire hit_stat  = wr_r.wr && (wr_r.addr == OFS_STAT);

  // byte-level slave sequencing
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    shift_nxt = shift_r;
    tx_nxt    = tx_r;
    ptr_nxt   = ptr_r;
    rw_nxt    = rw_r;
    acked_nxt = acked_r;
    oe_nxt    = oe_want_r;
    wr_nxt    = '0;
    if (stop_w) begin
      state_nxt = ST_IDLE;
      oe_nxt    = 1'b0;
    end else if (start_w) begin
      state_nxt = ST_ADDR;
      cnt_nxt   = 4'h0;
      oe_nxt    = 1'b0;
    end else begin
      case (state_r)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise) begin
            shift_nxt = {shift_r[6:0], sda_s};
            cnt_nxt   = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == BYTE_BITS) begin
            cnt_nxt = 4'h0;
            oe_nxt  = 1'b1;
            if (state_r == ST_ADDR) begin
              if (shift_r[7:1] == SLAVE_ADDR) begin
                rw_nxt    = shift_r[0];
                state_nxt = ST_ADDR_ACK;
              end else begin
                oe_nxt    = 1'b0;
                state_nxt = ST_IDLE;
              end
            end else if (state_r == ST_PTR) begin
              ptr_nxt   = shift_r;
              state_nxt = ST_PTR_ACK;
            end else begin
              wr_nxt.wr   = 1'b1;
              wr_nxt.addr = ptr_r;
              wr_nxt.data = shift_r;
              state_nxt   = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            if (state_r == ST_ADDR_ACK && rw_r) begin
              tx_nxt    = rd_byte;
              oe_nxt    = ~rd_byte[7];
              state_nxt = ST_RDATA;
            end else begin
              oe_nxt    = 1'b0;
              state_nxt = (state_r == ST_ADDR_ACK) ? ST_PTR : ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (cnt_r == BYTE_BITS) begin
              oe_nxt    = 1'b0;
              cnt_nxt   = 4'h0;
              state_nxt = ST_RDATA_ACK;
            end else begin
              tx_nxt = {tx_r[6:0], 1'b0};
              oe_nxt = ~tx_r[6];
            end
          end
        end
        ST_RDATA_ACK: begin
          if (scl_rise) begin
            acked_nxt = ~sda_s;
          end else if (scl_fall) begin
            if (acked_r) begin
              tx_nxt    = rd_byte;
              oe_nxt    = ~rd_byte[7];
              state_nxt = ST_RDATA;
            end else begin
              state_nxt = ST_IDLE;
            end
          end
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  // engine registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r   <= ST_IDLE;
      cnt_r     <= 4'h0;
      shift_r   <= 8'h00;
      tx_r      <= 8'h00;
      ptr_r     <= 8'h00;
      rw_r      <= 1'b0;
      acked_r   <= 1'b0;
      oe_want_r <= 1'b0;
      wr_r      <= '0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      shift_r   <= shift_nxt;
      tx_r      <= tx_nxt;
      ptr_r     <= ptr_nxt;
      rw_r      <= rw_nxt;
      acked_r   <= acked_nxt;
      oe_want_r <= oe_nxt;
      wr_r      <= wr_nxt;
    end
  end

  // data out changes only after the hold time past clock low
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_r   <= 7'h00;
      sda_oe_r <= 1'b0;
    end else if (scl_fall) begin
      hold_r <= HD_CYC_W;
    end else if (hold_r != 7'h00) begin
      hold_r <= hold_r - 7'h01;
    end else begin
      sda_oe_r <= oe_want_r;
    end
  end

  // control registers; read-only bits have no storage
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_r   <= RST_CODE;
      range_r  <= RST_RANGE;
      fpwm_r   <= RST_FPWM;
      trim_a_r <= RST_TRIM_A;
      trim_b_r <= RST_TRIM_B;
    end else begin
      if (hit_level) begin
        code_r  <= wr_r.data[CODE_MSB:0];
        range_r <= wr_r.data[RANGE_BIT];
      end
      if (hit_mode) fpwm_r <= wr_r.data[FPWM_BIT];
      if (hit_trima) trim_a_r <= wr_r.data[7:TRIM_A_LSB];
      if (hit_stat) begin
        trim_b_r <= {wr_r.data[TRIM_B4_BIT], wr_r.data[TRIM_B2_BIT],
                     wr_r.data[TRIM_B0_BIT]};
      end
    end
  end

  // registered level lookup
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lvl_valid_r <= 1'b0;
      mv_r        <= 13'h0000;
    end else begin
      lvl_valid_r <= lvl_w.valid;
      mv_r        <= lvl_w.mv;
    end
  end

  // outputs
  assign sda_o                = 1'b0; // open drain, low when enabled
  assign sda_oe_o             = sda_oe_r;
  assign output_level_code_o  = code_r;
  assign level_range_select_o = range_r;
  assign forced_pwm_o         = fpwm_r;
  assign trim_a_o             = trim_a_r;
  assign trim_b_o             = trim_b_r;
  assign level_valid_o        = lvl_valid_r;
  assign target_mv_o          = mv_r;
endmodule

// [testbench/bocr_host_model.sv]
`timescale 1ns/1ps
// two-wire bus master standing in for the host processor
module bocr_host_model #(
  parameter int H = 100
) (
  // clock
  input  wire logic ref_clk_i,
  // resolved data wire in, pins out
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // idle bus, both lines released
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // wait reference cycles
  task automatic hp(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // one bit: data moves in clock low, sampled mid clock high
  task automatic bit_io(input logic b, output logic s);
    hp(20);
    sda_o <= b;
    hp(H - 20);
    scl_o <= 1'b1;
    hp(H / 2);
    s = sda_i;
    hp(H / 2);
    scl_o <= 1'b0;
  endtask
  // start or repeated start: data falls while clock high
  task automatic start();
    hp(20);
    sda_o <= 1'b1;
    hp(H);
    scl_o <= 1'b1;
    hp(H);
    sda_o <= 1'b0;
    hp(H);
    scl_o <= 1'b0;
  endtask
  // stop: data rises while clock high
  task automatic stop();
    hp(20);
    sda_o <= 1'b0;
    hp(H);
    scl_o <= 1'b1;
    hp(H);
    sda_o <= 1'b1;
    hp(H);
  endtask
  // byte out msb first, returns the acknowledge
  task automatic send(input logic [7:0] d, output logic k);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    k = ~s;
  endtask
  // byte in msb first, then not-acknowledge
  task automatic recv(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(1'b1, s);
  endtask
endmodule

// [testbench/bocr_regs_checker.sv]
`timescale 1ns/1ps
// timing and level checks on the register bank ports
module bocr_regs_checker
  import bocr_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  // two-wire pins
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_o,
  // converter side
  input wire logic        power_good_i,
  input wire logic [5:0]  output_level_code_o,
  input wire logic        level_range_select_o,
  input wire logic        forced_pwm_o,
  input wire logic [1:0]  trim_a_o,
  input wire logic [2:0]  trim_b_o,
  input wire logic        level_valid_o,
  input wire logic [12:0] target_mv_o
);
  logic [6:0] lvl_q_r;
  logic       run_r;
  logic       held;
  logic [5:0] ofs;
  // level setting one edge back, so outputs have settled
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lvl_q_r <= 7'h00;
      run_r   <= 1'b0;
    end else begin
      lvl_q_r <= {level_range_select_o, output_level_code_o};
      run_r   <= 1'b1;
    end
  end
  // setting unchanged since the previous edge
  assign held = run_r &&
                (lvl_q_r == {level_range_select_o, output_level_code_o});
  assign ofs  = output_level_code_o - LOW_FIRST_CODE;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  high_target_a: assert property (
    held && level_range_select_o |-> level_valid_o &&
    target_mv_o == HI_BASE_MV + HI_STEP_MV * output_level_code_o)
    else $error("high range target wrong");
  low_target_a: assert property (
    held && !level_range_select_o && output_level_code_o >= LOW_FIRST_CODE
    |-> level_valid_o && target_mv_o == {1'b0, LOW_MV[ofs]})
    else $error("low range target wrong");
  low_gap_a: assert property (
    held && !level_range_select_o && output_level_code_o < LOW_FIRST_CODE
    |-> !level_valid_o) else $error("unavailable code shown valid");
  gap_zero_a: assert property (
    !level_valid_o |-> target_mv_o == 13'h0000)
    else $error("target not zero while invalid");
  drive_low_a: assert property (
    sda_oe_o |-> !sda_o) else $error("enabled data pin not low");
  oe_steady_a: assert property (
    $changed(sda_oe_o) |-> !scl_i) else $error("data moved, clock high");
  oe_hold_a: assert property (
    $fell(scl_i) |=> $stable(sda_oe_o) [*8]) else $error("data hold short");
  reg_timing_a: assert property (
    $changed({output_level_code_o, level_range_select_o, forced_pwm_o})
    |-> !scl_i) else $error("control changed outside a write");
  one_reg_a: assert property (
    $changed(forced_pwm_o) |->
    $stable({output_level_code_o, level_range_select_o}))
    else $error("mode write touched level");
endmodule
bind bocr_regs bocr_regs_checker u_chk (.ref_clk_i, .rst_n_i, .scl_i, .sda_i,
  .sda_o, .sda_oe_o, .power_good_i, .output_level_code_o,
  .level_range_select_o, .forced_pwm_o, .trim_a_o, .trim_b_o,
  .level_valid_o, .target_mv_o);

// [testbench/bocr_regs_test.sv]
`timescale 1ns/1ps
// register bank test through the two-wire host model
module bocr_regs_test
  import bocr_pkg::*;
;
  logic        ref_clk_i;
  logic        rst_n_i;
  logic        power_good_i;
  logic        scl;
  logic        host_sda;
  logic        sda_oe;
  wire         sda;
  logic [5:0]  code;
  logic        range;
  logic        fpwm;
  logic [1:0]  trim_a;
  logic [2:0]  trim_b;
  logic        valid;
  logic [12:0] mv;
  int          bad_count;
  int          n_checks;
  // open-drain data wire with pull-up
  assign sda = host_sda & ~sda_oe;
  bocr_regs uut (.ref_clk_i, .rst_n_i, .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe_o(sda_oe), .power_good_i, .output_level_code_o(code),
    .level_range_select_o(range), .forced_pwm_o(fpwm), .trim_a_o(trim_a),
    .trim_b_o(trim_b), .level_valid_o(valid), .target_mv_o(mv));
  bocr_host_model host (.ref_clk_i, .sda_i(sda), .scl_o(scl),
    .sda_o(host_sda));
  // 250 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  // compare one value
  task automatic chk(input string nm, input logic [11:0] e,
                     input logic [11:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // compare one target level
  task automatic chk_mv(input logic [12:0] e, input logic [12:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected mv expected %h seen %h", e, g);
    end
  endtask
  // single byte write frame
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic k;
    host.start();
    host.send({SLAVE_ADDR_DEF, 1'b0}, k);
    chk("ack", 12'h001, {11'h000, k});
    host.send(a, k);
    host.send(d, k);
    host.stop();
  endtask
  // single byte read frame with repeated start
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic k;
    host.start();
    host.send({SLAVE_ADDR_DEF, 1'b0}, k);
    host.send(a, k);
    host.start();
    host.send({SLAVE_ADDR_DEF, 1'b1}, k);
    host.recv(d);
    host.stop();
  endtask
  // reset values on the outputs
  task automatic t_reset();
    chk("level", {5'h00, RST_RANGE, RST_CODE}, {5'h00, range, code});
    chk("valid", 12'h001, {11'h000, valid});
    chk_mv(13'h044C, mv);
    chk("fpwm", 12'h000, {11'h000, fpwm});
  endtask
  // both ranges, code ends, read-only top bit
  task automatic t_level();
    logic [7:0]  v [4] = '{8'hE0, 8'h3F, 8'h7F, 8'h40};
    logic [12:0] m [4] = '{13'h0B22, 13'h08C5, 13'h1130, 13'h04E2};
    logic [7:0]  d;
    for (int i = 0; i < 4; i++) begin
      wr(OFS_LEVEL, v[i]);
      chk("level", {5'h00, v[i][6:0]}, {5'h00, range, code});
      chk_mv(m[i], mv);
      chk("valid", 12'h001, {11'h000, valid});
      if (i == 0) begin
        rd(OFS_LEVEL, d);
        chk("rd level", 12'h060, {4'h0, d});
      end
    end
  endtask
  // mode select and its read-only neighbours
  task automatic t_mode();
    logic [7:0] d;
    wr(OFS_MODE, 8'hFF);
    chk("fpwm", 12'h001, {11'h000, fpwm});
    rd(OFS_MODE, d);
    chk("rd mode", 12'h001, {4'h0, d});
    wr(OFS_MODE, 8'h00);
    chk("fpwm", 12'h000, {11'h000, fpwm});
  endtask
  // output-good flag follows the converter
  task automatic t_status();
    logic [7:0] d;
    wr(OFS_STAT, 8'h00);
    chk("trim", 12'h000, {7'h00, trim_a, trim_b});
    rd(OFS_STAT, d);
    chk("rd good", 12'h002, {4'h0, d});
    power_good_i <= 1'b0;
    rd(OFS_STAT, d);
    chk("rd bad", 12'h000, {4'h0, d});
  endtask
  // foreign address is not answered and changes nothing
  task automatic t_addr();
    logic k;
    host.start();
    host.send({SLAVE_ADDR_DEF ^ 7'h01, 1'b0}, k);
    host.stop();
    chk("nack", 12'h000, {11'h000, k});
    chk("level", 12'h040, {5'h00, range, code});
  endtask
  // verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (95000) @(posedge ref_clk_i);
    bad_count++;
    report_and_stop();
  end
  // main sequence
  initial begin
    bad_count = 0;
    n_checks = 0;
    rst_n_i = 1'b0;
    power_good_i = 1'b1;
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    t_reset();
    t_level();
    t_mode();
    t_status();
    t_addr();
    report_and_stop();
  end
endmodule
